//--- hdl/alu_pkg.sv
// Constants and enumerations for the arithmetic, logic and bit execution unit
// Assumes a single CLK domain; used by hdl/alu_core.sv and hdl/alu_exec.sv
package alu_pkg;
  // ==========================================
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  // ==========================================
  // Timing
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_RST = 2'h0;
  // ==========================================
  // Reset values and flag positions
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] CLEAR_VALUE = 8'h00;
  localparam int CARRY_POS = 7;
  localparam int DIGIT_POS = 3;
  // ==========================================
  // Operations
  typedef enum logic [3:0] {
    nop_op,
    literal_add_op,
    register_add_op,
    register_and_op,
    literal_and_op,
    bit_clear_op,
    bit_set_op,
    skip_if_bit_set_op,
    register_clear_op
  } op_t;
  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_skip
  } state_t;
endpackage : alu_pkg

//--- hdl/alu_exec.sv
// Combinational result and flag generator for one operation
// Assumes operands are stable while the operation is held
`timescale 1ns/1ps
module alu_exec (
  input wire logic [3:0] op,
  input wire logic [7:0] acc,
  input wire logic [7:0] reg_val,
  input wire logic [7:0] literal,
  input wire logic [2:0] bit_sel,
  output logic [7:0] result,
  output logic carry,
  output logic digit_carry,
  output logic zero,
  output logic bit_is_set
);
  // ==========================================
  // Datapath
  wire logic [8:0] add_b;
  wire logic [8:0] sum9;
  wire logic [4:0] low_sum;
  wire logic [7:0] bit_mask;
  wire alu_pkg::op_t op_e;
  assign op_e = alu_pkg::op_t'(op);
  assign add_b = (op_e == alu_pkg::literal_add_op) ? {1'b0, literal} : {1'b0, reg_val};
  assign sum9 = {1'b0, acc} + add_b;
  assign low_sum = {1'b0, acc[3:0]} + {1'b0, add_b[3:0]};
  assign bit_mask = 8'h01 << bit_sel;
  assign bit_is_set = reg_val[bit_sel];
  assign carry = sum9[alu_pkg::CARRY_POS + 1];
  assign digit_carry = low_sum[alu_pkg::DIGIT_POS + 1];
  assign zero = (result == 8'h00);
  always_comb begin
    case (op_e)
      alu_pkg::literal_add_op: result = sum9[7:0];
      alu_pkg::register_add_op: result = sum9[7:0];
      alu_pkg::register_and_op: result = acc & reg_val;
      alu_pkg::literal_and_op: result = acc & literal;
      alu_pkg::bit_clear_op: result = reg_val & ~bit_mask;
      alu_pkg::bit_set_op: result = reg_val | bit_mask;
      alu_pkg::register_clear_op: result = alu_pkg::CLEAR_VALUE;
      default: result = reg_val;
    endcase
  end
endmodule : alu_exec

//--- hdl/alu_core.sv
// What this block does
// - Literal add into accumulator, flags C DC Z
// - Register add, flags from the sum
// - Destination bit picks accumulator or register
// - Register AND, zero flag only, destination select
// - Literal AND into accumulator, zero only
// - Bit clear, other bits and flags kept
// - Bit set, other bits and flags kept
// - Bit test set skips next instruction
// - Register clear writes zero, sets zero flag
// - Four clocks per cycle, skip adds one
//
// Execution unit holding the accumulator and status flags
// Assumes the decoder presents the register value read at REG_ADDR on REG_RDATA combinationally
`timescale 1ns/1ps
module alu_core (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [7:0] OP_LITERAL,
  input wire logic [6:0] OP_ADDR,
  input wire logic [2:0] OP_BIT,
  input wire logic OP_DEST,
  input wire logic [7:0] REG_RDATA,
  output logic OP_READY,
  output logic [6:0] REG_ADDR,
  output logic REG_WE,
  output logic [7:0] REG_WDATA,
  output logic [7:0] ACC,
  output logic CARRY_FLAG,
  output logic DIGIT_CARRY_FLAG,
  output logic ZERO_FLAG,
  output logic SKIP_NEXT,
  output logic OP_DONE
);
  // ==========================================
  // Instruction cycle sequencing
  alu_pkg::state_t state_r, state_nxt;
  logic [1:0] phase_r;
  logic [3:0] op_r;
  logic [7:0] lit_r;
  logic [6:0] addr_r;
  logic [2:0] bit_r;
  logic dest_r;
  logic [7:0] acc_r;
  logic c_r, dc_r, z_r;
  logic we_r;
  logic [7:0] wdata_r;
  logic skip_r;
  logic done_r;
  logic ready_r;
  wire logic [7:0] result;
  wire logic carry, digit_carry, zero, bit_is_set;
  wire logic last_phase;
  wire logic accept;
  wire logic commit;
  wire alu_pkg::op_t op_e;
  wire logic upd_all, upd_zero, to_reg, to_acc, take_skip;

  alu_exec u_exec (
    .op(op_r),
    .acc(acc_r),
    .reg_val(REG_RDATA),
    .literal(lit_r),
    .bit_sel(bit_r),
    .result(result),
    .carry(carry),
    .digit_carry(digit_carry),
    .zero(zero),
    .bit_is_set(bit_is_set)
  );

  assign op_e = alu_pkg::op_t'(op_r);
  assign last_phase = (phase_r == alu_pkg::PHASE_LAST);
  // Requests while busy are dropped, not queued
  assign accept = (state_r == alu_pkg::st_idle) && OP_VALID;
  assign commit = (state_r == alu_pkg::st_exec) && last_phase;
  // Flag update classes
  assign upd_all = (op_e == alu_pkg::literal_add_op) || (op_e == alu_pkg::register_add_op);
  assign upd_zero = (op_e == alu_pkg::register_and_op) || (op_e == alu_pkg::literal_and_op)
      || (op_e == alu_pkg::register_clear_op);
  // Destination decode
  assign to_reg = (((op_e == alu_pkg::register_add_op) || (op_e == alu_pkg::register_and_op)) && dest_r)
      || (op_e == alu_pkg::bit_clear_op) || (op_e == alu_pkg::bit_set_op)
      || (op_e == alu_pkg::register_clear_op);
  assign to_acc = (((op_e == alu_pkg::register_add_op) || (op_e == alu_pkg::register_and_op)) && !dest_r)
      || (op_e == alu_pkg::literal_add_op) || (op_e == alu_pkg::literal_and_op);
  assign take_skip = (op_e == alu_pkg::skip_if_bit_set_op) && bit_is_set;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      alu_pkg::st_idle: if (OP_VALID) state_nxt = alu_pkg::st_exec;
      alu_pkg::st_exec: begin
        if (last_phase) begin
          state_nxt = take_skip ? alu_pkg::st_skip : alu_pkg::st_idle;
        end
      end
      // Second cycle is a no-operation of four clocks
      alu_pkg::st_skip: if (last_phase) state_nxt = alu_pkg::st_idle;
      default: state_nxt = alu_pkg::st_idle;
    endcase
  end

  wire logic [1:0] phase_nxt;
  // Idle parks the phase so every cycle starts at zero
  assign phase_nxt = (state_r == alu_pkg::st_idle) ? alu_pkg::PHASE_RST : phase_r + 2'h1;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= alu_pkg::st_idle;
      phase_r <= alu_pkg::PHASE_RST;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
    end
  end

  // ==========================================
  // Operand capture
  wire logic [3:0] op_nxt;
  wire logic [7:0] lit_nxt;
  wire logic [6:0] addr_nxt;
  wire logic [2:0] bit_nxt;
  wire logic dest_nxt;
  // Operands freeze for the whole cycle, so late decoder changes are harmless
  assign op_nxt = accept ? OP_CODE : op_r;
  assign lit_nxt = accept ? OP_LITERAL : lit_r;
  assign addr_nxt = accept ? OP_ADDR : addr_r;
  assign bit_nxt = accept ? OP_BIT : bit_r;
  assign dest_nxt = accept ? OP_DEST : dest_r;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      op_r <= 4'h0;
      lit_r <= 8'h00;
      addr_r <= 7'h00;
      bit_r <= 3'h0;
      dest_r <= 1'b0;
    end else begin
      op_r <= op_nxt;
      lit_r <= lit_nxt;
      addr_r <= addr_nxt;
      bit_r <= bit_nxt;
      dest_r <= dest_nxt;
    end
  end

  // ==========================================
  // Accumulator and flags
  wire logic [7:0] acc_nxt;
  wire logic c_nxt;
  wire logic dc_nxt;
  wire logic z_nxt;
  // Bit ops and the skip test fall in neither class, so flags hold
  assign acc_nxt = (commit && to_acc) ? result : acc_r;
  assign c_nxt = (commit && upd_all) ? carry : c_r;
  assign dc_nxt = (commit && upd_all) ? digit_carry : dc_r;
  assign z_nxt = (commit && (upd_all || upd_zero)) ? zero : z_r;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      acc_r <= alu_pkg::ACC_RST;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      c_r <= c_nxt;
      dc_r <= dc_nxt;
      z_r <= z_nxt;
    end
  end

  // ==========================================
  // Register file write
  wire logic we_nxt;
  wire logic [7:0] wdata_nxt;
  assign we_nxt = commit && to_reg;
  // Data follows the result every clock; only the strobe qualifies it
  assign wdata_nxt = result;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      we_r <= 1'b0;
      wdata_r <= 8'h00;
    end else begin
      we_r <= we_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // ==========================================
  // Handshake outputs
  wire logic skip_nxt;
  wire logic done_nxt;
  wire logic ready_nxt;
  assign skip_nxt = commit && take_skip;
  assign done_nxt = commit;
  // Ready looks one state ahead so it rises with the return to idle: with the commit, or after the skip cycle when one follows
  assign ready_nxt = (state_nxt == alu_pkg::st_idle);
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      skip_r <= 1'b0;
      done_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      skip_r <= skip_nxt;
      done_r <= done_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ==========================================
  // Output ports
  assign OP_READY = ready_r;
  assign REG_ADDR = addr_r;
  assign REG_WE = we_r;
  assign REG_WDATA = wdata_r;
  assign ACC = acc_r;
  assign CARRY_FLAG = c_r;
  assign DIGIT_CARRY_FLAG = dc_r;
  assign ZERO_FLAG = z_r;
  assign SKIP_NEXT = skip_r;
  assign OP_DONE = done_r;
endmodule : alu_core

//--- bench/alu_core_properties.sv
// Port timing checker for alu_core
// Assumes one CLK domain, bound to alu_core below
`timescale 1ns/1ps
module alu_core_properties (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [6:0] OP_ADDR,
  input wire logic OP_DEST,
  input wire logic OP_READY,
  input wire logic [6:0] REG_ADDR,
  input wire logic REG_WE,
  input wire logic [7:0] REG_WDATA,
  input wire logic CARRY_FLAG,
  input wire logic DIGIT_CARRY_FLAG,
  input wire logic ZERO_FLAG,
  input wire logic SKIP_NEXT,
  input wire logic OP_DONE
);
  // ==========================================
  // Properties
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire take = OP_VALID && OP_READY;
  wire [2:0] flg = {CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG};
  sequence s_busy; (!OP_READY && !OP_DONE) [*4]; endsequence
  sequence s_nop; (!OP_READY) [*4] ##1 OP_READY; endsequence
  property p_cycle; take |=> s_busy ##1 OP_DONE; endproperty
  property p_skip; SKIP_NEXT |-> OP_DONE and s_nop; endproperty
  property p_skflg; SKIP_NEXT |-> flg == $past(flg); endproperty
  property p_we; REG_WE |-> OP_DONE; endproperty
  property p_addr; take |=> REG_ADDR == $past(OP_ADDR); endproperty
  property p_clr; take && OP_CODE == alu_pkg::register_clear_op |-> ##5 REG_WE && REG_WDATA == 8'h00 && ZERO_FLAG;
  endproperty
  property p_bit; take && OP_CODE inside {alu_pkg::bit_set_op, alu_pkg::bit_clear_op} |-> ##5 REG_WE && $stable(flg);
  endproperty
  property p_and; take && OP_CODE inside {alu_pkg::literal_and_op, alu_pkg::register_and_op} |-> ##5 $stable(flg[2:1]);
  endproperty
  property p_dest; take && OP_CODE == alu_pkg::register_add_op |-> ##5 REG_WE == $past(OP_DEST, 5); endproperty
  a_cycle: assert property (p_cycle) else $error("commit timing");
  a_skip: assert property (p_skip) else $error("skip length");
  a_skflg: assert property (p_skflg) else $error("test moved flags");
  a_we: assert property (p_we) else $error("write outside commit");
  a_addr: assert property (p_addr) else $error("address capture");
  a_clr: assert property (p_clr) else $error("clear result");
  a_bit: assert property (p_bit) else $error("bit op flags");
  a_and: assert property (p_and) else $error("and moved carry");
  a_dest: assert property (p_dest) else $error("destination");
endmodule : alu_core_properties

bind alu_core alu_core_properties chk_u (.CLK, .SYS_RST, .OP_VALID, .OP_CODE, .OP_ADDR, .OP_DEST, .OP_READY,
  .REG_ADDR, .REG_WE, .REG_WDATA, .CARRY_FLAG, .DIGIT_CARRY_FLAG, .ZERO_FLAG, .SKIP_NEXT, .OP_DONE);

//--- bench/regfile_model.sv
// Data register file on the far side of alu_core
// Assumes writes on CLK and a combinational read
`timescale 1ns/1ps
module regfile_model (
  input wire logic clk,
  input wire logic [6:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // ==========================================
  // Storage
  logic [7:0] mem [128];
  // Seeded pattern, mirrored by the bench
  initial foreach (mem[i]) mem[i] = 8'(i * 29);
  assign rdata = mem[addr];
  always @(posedge clk) if (we) mem[addr] <= wdata;
endmodule : regfile_model

//--- bench/tb_top.sv
// Self-checking bench for alu_core against an integer model
// Assumes regfile_model on the far side and the bound checker
`timescale 1ns/1ps
module tb_top;
  // ==========================================
  // Signals and model state
  logic CLK = 1'b0, SYS_RST = 1'b1, OP_VALID = 1'b0, OP_DEST = 1'b0;
  logic [3:0] OP_CODE = 4'h0;
  logic [7:0] OP_LITERAL = 8'h00, REG_RDATA, REG_WDATA, ACC;
  logic [6:0] OP_ADDR = 7'h00, REG_ADDR;
  logic [2:0] OP_BIT = 3'h0;
  logic OP_READY, REG_WE, CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG, SKIP_NEXT, OP_DONE;
  int n_fail = 0, checks_done = 0, acc = 0, c = 0, dc = 0, z = 0, prev_sk = 0;
  int rf [128];
  alu_core dut_u (.CLK, .SYS_RST, .OP_VALID, .OP_CODE, .OP_LITERAL, .OP_ADDR, .OP_BIT, .OP_DEST, .REG_RDATA,
    .OP_READY, .REG_ADDR, .REG_WE, .REG_WDATA, .ACC, .CARRY_FLAG, .DIGIT_CARRY_FLAG, .ZERO_FLAG, .SKIP_NEXT, .OP_DONE);
  regfile_model far_u (.clk(CLK), .addr(REG_ADDR), .we(REG_WE), .wdata(REG_WDATA), .rdata(REG_RDATA));
  initial forever #5 CLK = ~CLK;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic rst_seq();
    SYS_RST = 1'b1;
    repeat (3) @(negedge CLK);
    SYS_RST = 1'b0;
    acc = 0;
    c = 0;
    dc = 0;
    z = 0;
    prev_sk = 0;
    @(negedge CLK);
    chk({1'b0, ACC, CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG, REG_WE, SKIP_NEXT, OP_DONE, OP_READY}, 16'h0001);
  endtask : rst_seq
  task automatic run(input int op, input int lit, input int a, input int b, input int d);
    int r, s, res, we, sk, k;
    r = rf[a];
    res = 0;
    sk = 0;
    s = (op == 1 || op == 4) ? lit : r;
    case (op)
      1, 2: begin
        c = (acc + s) > 255;
        dc = ((acc & 15) + (s & 15)) > 15;
        res = (acc + s) & 255;
      end
      3, 4: res = acc & s;
      5: res = r & ~(1 << b);
      6: res = r | (1 << b);
      7: sk = (r >> b) & 1;
      default: res = 0;
    endcase
    if (op inside {1, 2, 3, 4, 8})
      z = res == 0;
    we = op inside {5, 6, 8} || (op inside {2, 3} && d == 1);
    if (op inside {1, 4} || (op inside {2, 3} && d == 0))
      acc = res;
    if (we)
      rf[a] = res;
    for (k = 0; k < 20 && OP_READY !== 1'b1; k++) @(negedge CLK);
    chk(16'(k), 16'(prev_sk * 3));
    OP_VALID = 1'b1;
    OP_CODE = 4'(op);
    OP_LITERAL = 8'(lit);
    OP_ADDR = 7'(a);
    OP_BIT = 3'(b);
    OP_DEST = 1'(d);
    @(negedge CLK);
    // Request held while busy must be ignored
    OP_CODE = 4'h8;
    repeat (4) @(negedge CLK);
    chk({ACC, CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG, REG_WE, SKIP_NEXT, OP_DONE, 2'h0},
      {8'(acc), 1'(c), 1'(dc), 1'(z), 1'(we), 1'(sk), 1'b1, 2'h0});
    if (we)
      chk({8'h00, REG_WDATA}, 16'(res));
    chk({8'h00, OP_READY, REG_ADDR}, {8'h00, 1'(!sk), 7'(a)});
    OP_VALID = 1'b0;
    // One edge with the request low keeps back-to-back calls apart
    @(negedge CLK);
    prev_sk = sk;
  endtask : run
  initial begin
    void'($urandom(32'hc313));
    foreach (rf[i]) rf[i] = (i * 29) & 255;
    rst_seq();
    run(1, 255, 0, 0, 0);
    run(1, 1, 0, 0, 0);
    run(1, 8, 0, 0, 0);
    run(1, 8, 0, 0, 0);
    run(4, 0, 0, 0, 0);
    run(8, 0, 127, 0, 0);
    run(7, 0, 127, 3, 0);
    run(6, 0, 127, 3, 0);
    run(7, 0, 127, 3, 0);
    run(2, 0, 127, 0, 1);
    run(0, 77, 5, 0, 1);
    rst_seq();
    repeat (90) run($urandom_range(1, 8), $urandom_range(0, 255), $urandom_range(0, 127), $urandom_range(0, 7),
      $urandom_range(0, 1));
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge CLK);
    n_fail++;
    print_verdict();
  end
endmodule : tb_top
